// File: rtl/crs_pkg.sv
// package of constants and types for the core register set
package crs_pkg;
  localparam logic [7:0]  CRS_ACC_RST  = 8'h00;
  localparam logic [7:0]  CRS_IDX_RST  = 8'h00;
  localparam logic [15:0] CRS_PC_RST   = 16'h0000;
  localparam logic [7:0]  CRS_CC_RST   = 8'he8;
  localparam logic [15:0] CRS_SP_RST   = 16'h01ff;
  localparam int          CRS_CC_PRIH  = 5;
  localparam int          CRS_CC_PRIL  = 3;
  localparam int          CRS_CC_ZERO  = 1;
  localparam int          CRS_CC_NEG   = 2;

  // register selector used by instruction writes
  typedef enum logic [2:0]
  {
    CRS_SEL_ACC          = 3'b000,
    CRS_SEL_IDX          = 3'b001,
    CRS_SEL_PC_LOW_BYTE  = 3'b010,
    CRS_SEL_PC_HIGH_BYTE = 3'b011,
    CRS_SEL_SP           = 3'b100,
    CRS_SEL_CC           = 3'b101,
    CRS_SEL_NONE         = 3'b111
  } crs_sel_type;

  typedef struct packed
  {
    logic        we;
    crs_sel_type sel;
    logic [7:0]  data;
  } crs_wr_type;

  typedef struct packed
  {
    logic [7:0]  acc;
    logic [7:0]  idx1;
    logic [7:0]  idx2;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0]  cc;
  } crs_view_type;
endpackage

// File: rtl/crs_core_regs.sv
// programmer visible register set of the core
`timescale 1ns/10ps
module crs_core_regs
(
  input  wire logic                 mclk_i,       // core clock
  input  wire logic                 arst_n_i,     // async reset
  input  crs_pkg::crs_wr_type       wr_i,         // instruction register write
  input  wire logic                 prefix_i,     // prefix opcode decoded
  input  wire logic                 insn_done_i,  // instruction retires
  input  wire logic                 alu_we_i,     // alu result to accumulator
  input  wire logic [7:0]           alu_res_i,    // alu result
  input  wire logic                 pc_load_i,    // load pc (jump)
  input  wire logic [15:0]          pc_tgt_i,     // jump target
  input  wire logic                 pc_inc_i,     // advance pc by one
  input  wire logic                 irq_enter_i,  // interrupt entry
  input  wire logic [1:0]           irq_pri_i,    // priority of serviced entry
  input  wire logic                 irq_ret_i,    // return from interrupt
  input  crs_pkg::crs_view_type     ctx_i,        // popped context on return
  output crs_pkg::crs_view_type     view_o,       // register contents
  output logic                      idx_sel2_o    // current insn uses second index
);
  import crs_pkg::*;

  logic [7:0]   acc_q,          acc_d;
  logic [7:0]   idx1_q,         idx1_d;
  logic [7:0]   idx2_q,         idx2_d;
  logic [7:0]   pc_low_byte_q,  pc_low_byte_d;
  logic [7:0]   pc_high_byte_q, pc_high_byte_d;
  logic [15:0]  sp_q,           sp_d;
  logic [7:0]   cc_q,           cc_d;
  logic         pre_q,          pre_d;
  crs_view_type view_q,         view_d;
  logic         sel2_q,         sel2_d;

  // ----------------------------------------
  // next values
  // ----------------------------------------
  always_comb
  begin
    acc_d  = acc_q;
    idx1_d = idx1_q;
    idx2_d = idx2_q;
    pc_low_byte_d  = pc_low_byte_q;
    pc_high_byte_d = pc_high_byte_q;
    sp_d   = sp_q;
    cc_d   = cc_q;
    pre_d  = pre_q;
    if (prefix_i)
      pre_d = 1'b1;
    else if (insn_done_i)
      pre_d = 1'b0;
    if (alu_we_i)
    begin
      acc_d = alu_res_i;
      cc_d[CRS_CC_ZERO] = (alu_res_i == 8'h00);
      cc_d[CRS_CC_NEG]  = alu_res_i[7];
    end
    if (wr_i.we)
    begin
      unique case (wr_i.sel)
        CRS_SEL_ACC: acc_d = wr_i.data;
        CRS_SEL_IDX:
          if (pre_q)
            idx2_d = wr_i.data;
          else
            idx1_d = wr_i.data;
        CRS_SEL_PC_LOW_BYTE:  pc_low_byte_d  = wr_i.data;
        CRS_SEL_PC_HIGH_BYTE: pc_high_byte_d = wr_i.data;
        CRS_SEL_SP:           sp_d           = {sp_q[15:8], wr_i.data};
        CRS_SEL_CC:           cc_d           = wr_i.data;
        default:              ;
      endcase
    end
    if (pc_load_i)
      {pc_high_byte_d, pc_low_byte_d} = pc_tgt_i;
    else if (pc_inc_i)
      {pc_high_byte_d, pc_low_byte_d} = 16'({pc_high_byte_q, pc_low_byte_q} + 16'h0001);
    if (irq_ret_i)
    begin
      acc_d  = ctx_i.acc;
      idx1_d = ctx_i.idx1;
      {pc_high_byte_d, pc_low_byte_d} = ctx_i.pc;
      cc_d   = ctx_i.cc;
    end
    if (irq_enter_i)
    begin
      cc_d[CRS_CC_PRIH] = irq_pri_i[1];
      cc_d[CRS_CC_PRIL] = irq_pri_i[0];
    end
    view_d.acc  = acc_d;
    view_d.idx1 = idx1_d;
    view_d.idx2 = idx2_d;
    view_d.pc   = {pc_high_byte_d, pc_low_byte_d};
    view_d.sp   = sp_d;
    view_d.cc   = cc_d;
    sel2_d      = pre_d;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      acc_q  <= CRS_ACC_RST;
      idx1_q <= CRS_IDX_RST;
      idx2_q <= CRS_IDX_RST;
      pc_low_byte_q  <= CRS_PC_RST[7:0];
      pc_high_byte_q <= CRS_PC_RST[15:8];
      sp_q   <= CRS_SP_RST;
      cc_q   <= CRS_CC_RST;
      pre_q  <= 1'b0;
      view_q <= '{CRS_ACC_RST, CRS_IDX_RST, CRS_IDX_RST, CRS_PC_RST, CRS_SP_RST,
                  CRS_CC_RST};
      sel2_q <= 1'b0;
    end
    else
    begin
      acc_q  <= acc_d;
      idx1_q <= idx1_d;
      idx2_q <= idx2_d;
      pc_low_byte_q  <= pc_low_byte_d;
      pc_high_byte_q <= pc_high_byte_d;
      sp_q   <= sp_d;
      cc_q   <= cc_d;
      pre_q  <= pre_d;
      view_q <= view_d;
      sel2_q <= sel2_d;
    end
  end

  assign view_o     = view_q;
  assign idx_sel2_o = sel2_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  acc_result_a: assert property (
    alu_we_i && !wr_i.we && !irq_ret_i |=> view_o.acc == $past(alu_res_i))
    else $error("accumulator missed alu result");
  zero_flag_a: assert property (
    alu_we_i && !(wr_i.we && wr_i.sel == CRS_SEL_CC) && !irq_ret_i
    |=> view_o.cc[CRS_CC_ZERO] == ($past(alu_res_i) == 8'h00))
    else $error("zero flag wrong");
  // sign flag copies result bit seven
  sign_flag_a: assert property (
    alu_we_i && !(wr_i.we && wr_i.sel == CRS_SEL_CC) && !irq_ret_i
    |=> view_o.cc[CRS_CC_NEG] == $past(alu_res_i[7]))
    else $error("sign flag wrong");
  prefix_idx_a: assert property (
    prefix_i ##1 (wr_i.we && wr_i.sel == CRS_SEL_IDX && !irq_ret_i)
    |=> view_o.idx2 == $past(wr_i.data) && $stable(view_o.idx1))
    else $error("prefix did not steer to second index");
  sel2_set_a: assert property (prefix_i |=> idx_sel2_o)
    else $error("prefix flag not raised");
  sel2_clr_a: assert property (insn_done_i && !prefix_i |=> !idx_sel2_o)
    else $error("prefix flag not dropped");
  plain_idx_a: assert property (
    !pre_q && wr_i.we && wr_i.sel == CRS_SEL_IDX && !irq_ret_i
    |=> view_o.idx1 == $past(wr_i.data))
    else $error("first index not written");
  ret_idx2_a: assert property (
    irq_ret_i && !(wr_i.we && wr_i.sel == CRS_SEL_IDX) |=> $stable(view_o.idx2))
    else $error("return touched second index");
  ret_restore_a: assert property (
    irq_ret_i |=> view_o.acc == $past(ctx_i.acc) && view_o.idx1 == $past(ctx_i.idx1)
    && view_o.pc == $past(ctx_i.pc))
    else $error("return did not restore context");
  pri_load_a: assert property (
    irq_enter_i |=> view_o.cc[CRS_CC_PRIH] == $past(irq_pri_i[1])
    && view_o.cc[CRS_CC_PRIL] == $past(irq_pri_i[0]))
    else $error("priority bits not loaded");
  pc_inc_a: assert property (
    pc_inc_i && !pc_load_i && !irq_ret_i
    && !(wr_i.we && (wr_i.sel == CRS_SEL_PC_LOW_BYTE || wr_i.sel == CRS_SEL_PC_HIGH_BYTE))
    |=> view_o.pc == 16'($past(view_o.pc) + 16'h0001))
    else $error("pc did not advance");
  pc_load_a: assert property (
    pc_load_i && !irq_ret_i |=> view_o.pc == $past(pc_tgt_i))
    else $error("pc jump not taken");
  // low byte write keeps high byte
  pc_byte_a: assert property (
    wr_i.we && wr_i.sel == CRS_SEL_PC_LOW_BYTE && !pc_load_i && !pc_inc_i && !irq_ret_i
    |=> view_o.pc == {$past(view_o.pc[15:8]), $past(wr_i.data)})
    else $error("pc low byte write wrong");
  sp_high_a: assert property ($stable(view_o.sp[15:8]))
    else $error("stack pointer high byte moved");
  quiet_hold_a: assert property (
    !wr_i.we && !alu_we_i && !pc_load_i && !pc_inc_i && !irq_ret_i && !irq_enter_i
    |=> $stable(view_o))
    else $error("register changed with no instruction");

  // ----------------------------------------
  // scenario covers
  // ----------------------------------------
  prefix_cov_c: cover property (prefix_i ##1 (wr_i.we && wr_i.sel == CRS_SEL_IDX));
  irq_cov_c:    cover property (irq_enter_i ##[1:20] irq_ret_i);
  zero_cov_c:   cover property (alu_we_i && alu_res_i == 8'h00);
  carry_cov_c:  cover property (pc_inc_i && view_o.pc[7:0] == 8'hff);
endmodule

// File: tb/test_crs_core_regs.sv
// self-checking bench for the core register set
`timescale 1ns/10ps
module test_crs_core_regs;
  import crs_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic         mclk_i = 1'b0;
  logic         arst_n_i = 1'b0;
  crs_wr_type   wr_i = '0;
  logic         prefix_i = 1'b0, insn_done_i = 1'b0, alu_we_i = 1'b0;
  logic         pc_load_i = 1'b0, pc_inc_i = 1'b0, irq_enter_i = 1'b0;
  logic         irq_ret_i = 1'b0;
  logic [7:0]   alu_res_i = 8'h00;
  logic [15:0]  pc_tgt_i = 16'h0000;
  logic [1:0]   irq_pri_i = 2'h0;
  crs_view_type ctx_i = '0;
  crs_view_type v;
  logic         sel2;
  int           err_total = 0;
  int           checks = 0;

  always #50 mclk_i = ~mclk_i;

  crs_core_regs i_crs_core_regs
  (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .wr_i(wr_i), .prefix_i(prefix_i),
    .insn_done_i(insn_done_i), .alu_we_i(alu_we_i), .alu_res_i(alu_res_i),
    .pc_load_i(pc_load_i), .pc_tgt_i(pc_tgt_i), .pc_inc_i(pc_inc_i),
    .irq_enter_i(irq_enter_i), .irq_pri_i(irq_pri_i), .irq_ret_i(irq_ret_i),
    .ctx_i(ctx_i), .view_o(v), .idx_sel2_o(sel2)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // strobe bits of one step, in the order of the concatenation in step
  localparam logic [6:0] S_NONE  = 7'h00;
  localparam logic [6:0] S_PRE   = 7'h40;
  localparam logic [6:0] S_DONE  = 7'h20;
  localparam logic [6:0] S_ALU   = 7'h10;
  localparam logic [6:0] S_LOAD  = 7'h08;
  localparam logic [6:0] S_INC   = 7'h04;
  localparam logic [6:0] S_ENTER = 7'h02;
  localparam logic [6:0] S_RET   = 7'h01;
  localparam crs_wr_type NO_WR   = '0;

  // one cycle: set at a falling edge, taken at the next rising edge,
  // replaced by the next step at the falling edge after it
  task automatic step(input crs_wr_type w, input logic [6:0] s);
    wr_i = w;
    {prefix_i, insn_done_i, alu_we_i, pc_load_i, pc_inc_i, irq_enter_i, irq_ret_i} = s;
    @(negedge mclk_i);
  endtask

  task automatic wr(input crs_sel_type s, input logic [7:0] d);
    step('{we: 1'b1, sel: s, data: d}, S_NONE);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset contents
  task automatic t_reset;
    cmp({v.acc, v.idx1}, {CRS_ACC_RST, CRS_IDX_RST});
    cmp({8'h00, v.idx2}, {8'h00, CRS_IDX_RST});
    cmp(v.pc, CRS_PC_RST);
    cmp(v.sp, CRS_SP_RST);
    cmp({8'h00, v.cc}, {8'h00, CRS_CC_RST});
    cmp({15'h0000, sel2}, 16'h0000);
  endtask

  task automatic t_alu;
    alu_res_i = 8'h00;
    step(NO_WR, S_ALU);
    cmp({v.acc, 6'h00, v.cc[CRS_CC_NEG], v.cc[CRS_CC_ZERO]}, 16'h0001);
    alu_res_i = 8'h80;
    step(NO_WR, S_ALU);
    cmp({v.acc, 6'h00, v.cc[CRS_CC_NEG], v.cc[CRS_CC_ZERO]}, 16'h8002);
    wr(CRS_SEL_ACC, 8'h3c);
    cmp({8'h00, v.acc}, 16'h003c);
  endtask

  task automatic t_index;
    wr(CRS_SEL_IDX, 8'h33);
    cmp({v.idx1, v.idx2}, 16'h3300);
    step(NO_WR, S_PRE | S_DONE);
    cmp({15'h0000, sel2}, 16'h0001);
    wr(CRS_SEL_IDX, 8'h55);
    cmp({v.idx1, v.idx2}, 16'h3355);
    step(NO_WR, S_DONE);
    cmp({15'h0000, sel2}, 16'h0000);
    wr(CRS_SEL_IDX, 8'ha6);
    cmp({v.idx1, v.idx2}, 16'ha655);
  endtask

  task automatic t_pc;
    wr(CRS_SEL_PC_LOW_BYTE, 8'hff);
    wr(CRS_SEL_PC_HIGH_BYTE, 8'h12);
    cmp(v.pc, 16'h12ff);
    step(NO_WR, S_INC);
    cmp(v.pc, 16'h1300);
    pc_tgt_i = 16'habcd;
    step(NO_WR, S_LOAD | S_INC);
    cmp(v.pc, 16'habcd);
    wr(CRS_SEL_SP, 8'h40);
    cmp(v.sp, {CRS_SP_RST[15:8], 8'h40});
  endtask

  task automatic t_irq;
    for (int p = 0; p < 4; p++)
    begin
      irq_pri_i = 2'(p);
      step(NO_WR, S_ENTER);
      cmp({14'h0000, v.cc[CRS_CC_PRIH], v.cc[CRS_CC_PRIL]}, 16'(p));
    end
    ctx_i = '{8'h11, 8'h22, 8'h99, 16'h4567, 16'h0123, 8'h0a};
    step(NO_WR, S_RET);
    cmp({v.acc, v.idx1}, 16'h1122);
    cmp({v.idx2, v.cc}, 16'h550a);
    cmp(v.pc, 16'h4567);
    cmp(v.sp, {CRS_SP_RST[15:8], 8'h40});
  endtask

  // reset in mid-run clears at once
  task automatic t_reset_mid;
    arst_n_i = 1'b0;
    step(NO_WR, S_NONE);
    t_reset();
    arst_n_i = 1'b1;
    step(NO_WR, S_PRE);
    cmp({15'h0000, sel2}, 16'h0001);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (2) @(negedge mclk_i);
    arst_n_i = 1'b1;
    t_reset();
    t_alu();
    t_index();
    t_pc();
    t_irq();
    t_reset_mid();
    step(NO_WR, S_NONE);
    tally_and_finish();
  end

  // scenarios need about 23 cycles; the limit leaves ample margin
  initial
  begin
    repeat (500) @(negedge mclk_i);
    err_total++;
    tally_and_finish();
  end
endmodule
